// ==== sim/rhr_refgen.sv ====
// Purpose: two reference clock sources facing the block
// Assumes: a dead reference stands low
// Notes: B runs unless stopped; A pulses only on request
`timescale 1ns/10ps
module rhr_refgen #(
    parameter real HALF_NS = 51.3
) (
    // reference clocks
    output logic ref_a,
    output logic ref_b
);
    logic run_b;
    // off the bench clock grid, so the phase drifts
    initial begin
        ref_a = 1'h0;
        ref_b = 1'h0;
        run_b = 1'h1;
        forever begin
            #HALF_NS;
            // a stopped source stands low
            ref_b = run_b ? ~ref_b : 1'h0;
        end
    end
    task automatic pulse_a(input int n);
        repeat (n) begin
            ref_a = 1'h1;
            #HALF_NS;
            ref_a = 1'h0;
            #HALF_NS;
        end
    endtask
endmodule

// ==== sim/rhr_top_asserts.sv ====
// Purpose: port-level checks of the holdover block
// Assumes: one clock domain, async active-low reset
// Notes: bound to rhr_top from the bench top file
`timescale 1ns/10ps
module rhr_top_asserts #(
    parameter MON_DEFAULT = 16'h0040
) (
    // clock and reset
    input wire CLK,
    input wire RST_N,
    // references and loss flags
    input wire REF_A,
    input wire REF_B,
    input wire LOS_A,
    input wire LOS_B,
    // register bus
    input wire AWVALID,
    input wire AWREADY,
    input wire WVALID,
    input wire WREADY,
    input wire [1:0] BRESP,
    input wire BVALID,
    input wire BREADY,
    input wire [4:0] ARADDR,
    input wire ARVALID,
    input wire ARREADY,
    input wire [31:0] RDATA,
    input wire [1:0] RRESP,
    input wire RVALID,
    input wire RREADY
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);
    // cycles since a rising reference edge; saturates, no wrap
    reg [15:0] qa_q;
    reg [15:0] qb_q;
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            qa_q <= 16'h0000;
            qb_q <= 16'h0000;
        end else begin
            qa_q <= $rose(REF_A) ? 16'h0000 : qa_q + {15'h0000, ~&qa_q};
            qb_q <= $rose(REF_B) ? 16'h0000 : qb_q + {15'h0000, ~&qb_q};
        end
    end
    a_b_holds: assert property (BVALID && !BREADY |=>
        BVALID && $stable(BRESP)) else $error("write response dropped");
    a_r_holds: assert property (RVALID && !RREADY |=>
        RVALID && $stable(RDATA)) else $error("read data dropped");
    a_w_refused: assert property (BVALID |-> !AWREADY && !WREADY)
        else $error("write taken while response pending");
    a_ar_refused: assert property (RVALID |-> !ARREADY)
        else $error("read taken while data pending");
    a_write_answer: assert property (AWVALID && AWREADY && WVALID &&
        WREADY |-> ##2 BVALID) else $error("no write response");
    a_read_answer: assert property (ARVALID && ARREADY |=> RVALID)
        else $error("no read data");
    a_unmapped_rd: assert property (ARVALID && ARREADY && ARADDR > 5'h13
        |=> RRESP == 2'h2 && RDATA == 32'h0) else $error("bad unmapped");
    // slack of 4 covers the input synchroniser
    a_los_a_miss: assert property (
        $rose(LOS_A) |-> qa_q >= MON_DEFAULT - 4)
        else $error("loss on A without a missing edge");
    a_los_b_miss: assert property (
        $rose(LOS_B) |-> qb_q >= MON_DEFAULT - 4)
        else $error("loss on B without a missing edge");
    a_los_a_clear: assert property (
        $fell(LOS_A) |-> qa_q <= 16'h0008)
        else $error("loss on A cleared without an edge");
endmodule

// ==== sim/rhr_top_tb.sv ====
// Purpose: register and reference scenarios for rhr_top
// Assumes: prescaler code 0 keeps the hold-off run short
// Notes: bus sampled at negedge, released after the next posedge
`timescale 1ns/10ps
module rhr_top_tb;
    logic clk, rst_n, external_select_mode, awvalid, wvalid, bready, arvalid, rready;
    logic [4:0] awaddr, araddr;
    logic [31:0] wdata, d;
    logic [3:0] wstrb;
    logic [1:0] r;
    wire aw_rdy, w_rdy, b_vld, ar_rdy, r_vld, act, los_a, los_b, ref_a, ref_b;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    int err_total, tests_run, n, cyc;
    int lens[4] = '{2, 16, 32, 64};
    rhr_top #(.MON_DEFAULT(16'h0040)) rhr_top_inst (.CLK(clk),
        .RST_N(rst_n), .REF_A(ref_a), .REF_B(ref_b), .EXTERNAL_SELECT_MODE_PIN(external_select_mode),
        .REF_ACTIVE(act), .LOS_A(los_a), .LOS_B(los_b), .AWADDR(awaddr),
        .AWVALID(awvalid), .AWREADY(aw_rdy), .WDATA(wdata), .WSTRB(wstrb),
        .WVALID(wvalid), .WREADY(w_rdy), .BRESP(bresp), .BVALID(b_vld),
        .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
        .ARREADY(ar_rdy), .RDATA(rdata), .RRESP(rresp), .RVALID(r_vld),
        .RREADY(rready));
    rhr_refgen rhr_refgen_inst (.ref_a(ref_a), .ref_b(ref_b));
    // ----------------------------------------------------------------
    // bus and check tasks
    // ----------------------------------------------------------------
    task automatic wr(input logic [4:0] a, input logic [31:0] v);
        logic ta, tw, tb;
        tb = 1'h0;
        @(posedge clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        while (!tb) begin
            @(negedge clk);
            ta = awvalid & aw_rdy;
            tw = wvalid & w_rdy;
            tb = b_vld;
            r = bresp;
            @(posedge clk);
            if (ta) awvalid <= 1'h0;
            if (tw) wvalid <= 1'h0;
        end
        bready <= 1'h0;
    endtask
    // w holds rready low for w cycles to stall the read answer
    task automatic rd(input logic [4:0] a, input int w = 0);
        logic ta, tr;
        tr = 1'h0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= (w == 0);
        while (!tr) begin
            @(negedge clk);
            ta = arvalid & ar_rdy;
            tr = r_vld & rready;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (ta) arvalid <= 1'h0;
            if (w > 0) w--;
            if (w == 0 && !tr) rready <= 1'h1;
        end
        rready <= 1'h0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic rc(input logic [4:0] a, input logic [31:0] exp);
        rd(a);
        chk(d, exp);
        chk(r, 32'h0);
    endtask
    task automatic idle(input int k);
        repeat (k) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic pa(input int k);
        rhr_refgen_inst.pulse_a(k);
        idle(2);
    endtask
    task automatic conclude;
        $display("Checks %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // ----------------------------------------------------------------
    // clock, timeout, scenarios
    // ----------------------------------------------------------------
    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end
    // longest case is the hold-off wait, two 32768-cycle ticks
    initial begin
        cyc = 0;
        forever begin
            @(posedge clk);
            cyc++;
            if (cyc == 95000) begin
                err_total++;
                $display("Error at %0t: run too long", $time);
                conclude();
            end
        end
    end
    initial begin
        {rst_n, external_select_mode, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
        {awaddr, araddr, wdata, wstrb} = 46'h00000000000F;
        repeat (3) @(posedge clk);
        rst_n <= 1'h1;
        rc(5'h00, 32'h20);
        rc(5'h04, 32'h280);
        rc(5'h08, 32'h2);
        rc(5'h0C, 32'h40);
        rd(5'h0C, 3);
        chk(d, 32'h40);
        wr(5'h04, 32'h1A5);
        rc(5'h04, 32'h1A5);
        rd(5'h14);
        chk(d, 32'h0);
        chk(r, 32'h2);
        wr(5'h18, 32'h1);
        chk(r, 32'h2);
        wr(5'h00, 32'h21);
        idle(4);
        chk(act, 32'h1);
        wr(5'h00, 32'h01);
        idle(6);
        chk(act, 32'h0);
        @(posedge clk);
        external_select_mode <= 1'h1;
        idle(6);
        chk(act, 32'h1);
        wr(5'h00, 32'h20);
        for (int c = 0; c < 4; c++) begin
            wr(5'h08, 32'(c));
            idle(150);
            pa(lens[c] - 1);
            chk(los_a, 32'h1);
            pa(1);
            chk(los_a, 32'h0);
        end
        wr(5'h08, 32'h0);
        idle(150);
        pa(1);
        idle(100);
        pa(1);
        chk(los_a, 32'h1);
        rhr_refgen_inst.run_b = 1'h0;
        idle(150);
        chk(los_b, 32'h1);
        rhr_refgen_inst.run_b = 1'h1;
        idle(100);
        chk(los_b, 32'h0);
        wr(5'h00, 32'h22);
        idle(150);
        chk(act, 32'h1);
        pa(2);
        chk(act, 32'h1);
        wr(5'h00, 32'h2A);
        idle(150);
        pa(2);
        chk(act, 32'h0);
        wr(5'h04, 32'h002);
        wr(5'h00, 32'h24);
        pa(2);
        idle(20000);
        chk(act, 32'h0);
        rd(5'h10);
        chk(d[3], 32'h1);
        n = 0;
        while (act !== 1'h1 && n < 60000) begin
            @(negedge clk);
            n++;
        end
        chk(act, 32'h1);
        // code 00 ticks every 2^15 cycles, so a period of 2 spans one to two
        chk(20000 + n > 32768 && 20000 + n < 65636, 32'h1);
        rd(5'h10);
        chk(d[15:8], 32'h2);
        conclude();
    end
endmodule
bind rhr_top rhr_top_asserts #(.MON_DEFAULT(MON_DEFAULT))
    rhr_top_asserts_inst (
    .CLK(CLK), .RST_N(RST_N), .REF_A(REF_A), .REF_B(REF_B), .LOS_A(LOS_A),
    .LOS_B(LOS_B), .AWVALID(AWVALID), .AWREADY(AWREADY), .WVALID(WVALID),
    .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
    .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA),
    .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY));

// ==== src/rhr_consts.vh ====
// What this block does
// - Hold-off counter counts down once the active input loses signal.
// - Hold-off counter reaching zero performs a reference fail-over switch.
// - Hold-off period is an 8-bit count of prescaled ticks, reset 0x80.
// - Hold-off counter reloads its setting after every transition to zero.
// - Tick is clock / 2^15, 2^16, 2^17 for prescaler 00, 01, 10; reset 10.
// - Defaults at 122.88 MHz give about 136 ms, 128 ticks of clock/2^17.
// - Revalidation code 00/01/10/11 means 2/16/32/64 periods, reset 10.
// - Loss loads the revalidation counter; each valid period decrements it.
// - A missing edge for one period reloads the revalidation counter.
// - Revalidation counter reaching zero clears that input's loss flag.
// - Auto modes pick from loss states and select bit; manual uses the bit.
// - Revertive auto mode returns to the primary when it revalidates.
//
// Purpose: constants of the reference holdover and revalidation block
// Assumes: 32-bit AXI4-Lite register slave
// Notes: offsets are byte addresses
`ifndef RHR_CONSTS_VH
`define RHR_CONSTS_VH
// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define RHR_ADDR_CTRL 5'h00
`define RHR_ADDR_HOLD 5'h04
`define RHR_ADDR_REVAL 5'h08
`define RHR_ADDR_MON 5'h0C
`define RHR_ADDR_STAT 5'h10
`define RHR_RESP_OKAY 2'h0
`define RHR_RESP_SLVERR 2'h2
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RHR_RST_SEL 1'h0
`define RHR_RST_MODE 2'h0
`define RHR_RST_EXT 2'h2
`define RHR_RST_PERIOD 8'h80
`define RHR_RST_PRESC 2'h2
`define RHR_RST_REVAL 2'h2
// ----------------------------------------------------------------
// encodings
// ----------------------------------------------------------------
`define RHR_EXT_INTERNAL 2'h2
`define RHR_MODE_MAN_HOLD 2'h0
`define RHR_MODE_AUTO 2'h1
`define RHR_MODE_SHORT_HOLD 2'h2
`define RHR_MODE_AUTO_HOLD 2'h3
`define RHR_PRESC_15 2'h0
`define RHR_PRESC_16 2'h1
`define RHR_MASK_15 17'h07FFF
`define RHR_MASK_16 17'h0FFFF
`define RHR_MASK_17 17'h1FFFF
`define RHR_REV_2 7'h02
`define RHR_REV_16 7'h10
`define RHR_REV_32 7'h20
`define RHR_REV_64 7'h40
// default timing at a 122.88 MHz clock: 128 ticks of 2^17 cycles
`define RHR_HOLD_DEFAULT_MS 136
`endif

// ==== src/rhr_top.v ====
// Purpose: reference supervision, short-term holdover, revalidation
// Assumes: CLK is the VCXO-derived clock; reference pins are asynchronous
// Notes: registers over AXI4-Lite, one write and one read at a time
`timescale 1ns/10ps
`include "rhr_consts.vh"
module rhr_top #(
    parameter MON_DEFAULT = 16'h0040
) (
    // clock and reset
    input wire CLK,
    input wire RST_N,
    // reference inputs and external select
    input wire REF_A,
    input wire REF_B,
    input wire EXTERNAL_SELECT_MODE_PIN,
    // selection status
    output reg REF_ACTIVE,
    output reg LOS_A,
    output reg LOS_B,
    // axi4-lite write address
    input wire [4:0] AWADDR,
    input wire AWVALID,
    output wire AWREADY,
    // axi4-lite write data
    input wire [31:0] WDATA,
    input wire [3:0] WSTRB,
    input wire WVALID,
    output wire WREADY,
    // axi4-lite write response
    output reg [1:0] BRESP,
    output reg BVALID,
    input wire BREADY,
    // axi4-lite read address
    input wire [4:0] ARADDR,
    input wire ARVALID,
    output wire ARREADY,
    // axi4-lite read data
    output reg [31:0] RDATA,
    output reg [1:0] RRESP,
    output reg RVALID,
    input wire RREADY
);
    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    reg sel_q;
    reg [1:0] mode_q;
    reg rev_en_q;
    reg [1:0] ext_q;
    reg [7:0] period_q;
    reg [1:0] presc_q;
    reg [1:0] reval_q;
    reg [15:0] mon_q;
    // ------------------------------------------------------------
    // axi write path
    // ------------------------------------------------------------
    reg aw_full_q;
    reg w_full_q;
    reg [4:0] aw_addr_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;
    wire do_write;
    assign AWREADY = !aw_full_q && !BVALID;
    assign WREADY = !w_full_q && !BVALID;
    assign do_write = aw_full_q && w_full_q && !BVALID;
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            aw_addr_q <= 5'h00;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
            BVALID <= 1'b0;
            BRESP <= `RHR_RESP_OKAY;
        end else begin
            if (AWVALID && AWREADY) begin
                aw_full_q <= 1'b1;
                aw_addr_q <= AWADDR;
            end
            if (WVALID && WREADY) begin
                w_full_q <= 1'b1;
                w_data_q <= WDATA;
                w_strb_q <= WSTRB;
            end
            if (do_write) begin
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                BVALID <= 1'b1;
                case (aw_addr_q)
                    `RHR_ADDR_CTRL, `RHR_ADDR_HOLD,
                    `RHR_ADDR_REVAL, `RHR_ADDR_MON,
                    `RHR_ADDR_STAT: BRESP <= `RHR_RESP_OKAY;
                    default: BRESP <= `RHR_RESP_SLVERR;
                endcase
            end else if (BVALID && BREADY) begin
                BVALID <= 1'b0;
            end
        end
    end
    // configuration writes; status is read only
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            sel_q <= `RHR_RST_SEL;
            mode_q <= `RHR_RST_MODE;
            rev_en_q <= 1'b0;
            ext_q <= `RHR_RST_EXT;
            period_q <= `RHR_RST_PERIOD;
            presc_q <= `RHR_RST_PRESC;
            reval_q <= `RHR_RST_REVAL;
            mon_q <= MON_DEFAULT;
        end else if (do_write) begin
            case (aw_addr_q)
                `RHR_ADDR_CTRL: begin
                    if (w_strb_q[0]) begin
                        sel_q <= w_data_q[0];
                        mode_q <= w_data_q[2:1];
                        rev_en_q <= w_data_q[3];
                        ext_q <= w_data_q[5:4];
                    end
                end
                `RHR_ADDR_HOLD: begin
                    if (w_strb_q[0]) begin
                        period_q <= w_data_q[7:0];
                    end
                    if (w_strb_q[1]) begin
                        presc_q <= w_data_q[9:8];
                    end
                end
                `RHR_ADDR_REVAL: begin
                    if (w_strb_q[0]) begin
                        reval_q <= w_data_q[1:0];
                    end
                end
                `RHR_ADDR_MON: begin
                    if (w_strb_q[0]) begin
                        mon_q[7:0] <= w_data_q[7:0];
                    end
                    if (w_strb_q[1]) begin
                        mon_q[15:8] <= w_data_q[15:8];
                    end
                end
                default: begin
                end
            endcase
        end
    end
    // ------------------------------------------------------------
    // axi read path
    // ------------------------------------------------------------
    reg hold_run_q;
    reg [7:0] hold_cnt_q;
    reg [31:0] rd_mux;
    assign ARREADY = !RVALID;
    always @* begin
        rd_mux = 32'h00000000;
        case (ARADDR)
            `RHR_ADDR_CTRL:
                rd_mux[5:0] = {ext_q, rev_en_q, mode_q, sel_q};
            `RHR_ADDR_HOLD: rd_mux[9:0] = {presc_q, period_q};
            `RHR_ADDR_REVAL: rd_mux[1:0] = reval_q;
            `RHR_ADDR_MON: rd_mux[15:0] = mon_q;
            `RHR_ADDR_STAT:
                rd_mux[15:0] = {hold_cnt_q, 4'h0, hold_run_q,
                                REF_ACTIVE, LOS_B, LOS_A};
            default: rd_mux = 32'h00000000;
        endcase
    end
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            RVALID <= 1'b0;
            RDATA <= 32'h00000000;
            RRESP <= `RHR_RESP_OKAY;
        end else if (ARVALID && ARREADY) begin
            RVALID <= 1'b1;
            RDATA <= rd_mux;
            case (ARADDR)
                `RHR_ADDR_CTRL, `RHR_ADDR_HOLD,
                `RHR_ADDR_REVAL, `RHR_ADDR_MON,
                `RHR_ADDR_STAT: RRESP <= `RHR_RESP_OKAY;
                default: RRESP <= `RHR_RESP_SLVERR;
            endcase
        end else if (RVALID && RREADY) begin
            RVALID <= 1'b0;
        end
    end
    // ------------------------------------------------------------
    // input synchronisers and edge detect
    // ------------------------------------------------------------
    reg [2:0] sync_a_q;
    reg [2:0] sync_b_q;
    reg [1:0] sync_x_q;
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            sync_a_q <= 3'h0;
            sync_b_q <= 3'h0;
            sync_x_q <= 2'h0;
        end else begin
            sync_a_q <= {sync_a_q[1:0], REF_A};
            sync_b_q <= {sync_b_q[1:0], REF_B};
            sync_x_q <= {sync_x_q[0], EXTERNAL_SELECT_MODE_PIN};
        end
    end
    // edges taken from stages two and three, never stage one
    wire [1:0] edge_in;
    assign edge_in[0] = sync_a_q[1] && !sync_a_q[2];
    assign edge_in[1] = sync_b_q[1] && !sync_b_q[2];
    // ------------------------------------------------------------
    // per-input loss monitor and revalidation counter
    // ------------------------------------------------------------
    reg [6:0] reval_len;
    always @* begin
        case (reval_q)
            2'h0: reval_len = `RHR_REV_2;
            2'h1: reval_len = `RHR_REV_16;
            2'h2: reval_len = `RHR_REV_32;
            default: reval_len = `RHR_REV_64;
        endcase
    end
    reg [15:0] wd_q [0:1];
    reg [6:0] rv_q [0:1];
    reg [1:0] los_q;
    reg [1:0] reval_done_q;
    wire [1:0] miss;
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_mon
            // a window of mon_q cycles without an edge is a missed period
            assign miss[gi] = (wd_q[gi] >= mon_q) && !edge_in[gi];
            always @(posedge CLK or negedge RST_N) begin
                if (!RST_N) begin
                    wd_q[gi] <= 16'h0000;
                    rv_q[gi] <= 7'h00;
                    los_q[gi] <= 1'b0;
                    reval_done_q[gi] <= 1'b0;
                end else begin
                    reval_done_q[gi] <= 1'b0;
                    if (edge_in[gi] || miss[gi]) begin
                        wd_q[gi] <= 16'h0000;
                    end else begin
                        wd_q[gi] <= wd_q[gi] + 16'h0001;
                    end
                    if (miss[gi]) begin
                        los_q[gi] <= 1'b1;
                        rv_q[gi] <= reval_len;
                    end else if (los_q[gi] && edge_in[gi]) begin
                        if (rv_q[gi] <= 7'h01) begin
                            los_q[gi] <= 1'b0;
                            reval_done_q[gi] <= 1'b1;
                            rv_q[gi] <= 7'h00;
                        end else begin
                            rv_q[gi] <= rv_q[gi] - 7'h01;
                        end
                    end
                end
            end
        end
    endgenerate
    // ------------------------------------------------------------
    // hold-off prescaler
    // ------------------------------------------------------------
    reg [16:0] pre_q;
    reg [16:0] pre_mask;
    wire tick;
    always @* begin
        case (presc_q)
            `RHR_PRESC_15: pre_mask = `RHR_MASK_15;
            `RHR_PRESC_16: pre_mask = `RHR_MASK_16;
            default: pre_mask = `RHR_MASK_17;
        endcase
    end
    // free-running count; the first tick after a loss may come early
    assign tick = (pre_q & pre_mask) == pre_mask;
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            pre_q <= 17'h00000;
        end else begin
            pre_q <= pre_q + 17'h00001;
        end
    end
    // ------------------------------------------------------------
    // reference selection and hold-off counter
    // ------------------------------------------------------------
    wire internal = (ext_q == `RHR_EXT_INTERNAL);
    wire manual = !mode_q[0];
    wire uses_hold = (mode_q == `RHR_MODE_SHORT_HOLD) ||
                     (mode_q == `RHR_MODE_AUTO_HOLD);
    wire los_act = REF_ACTIVE ? los_q[1] : los_q[0];
    wire los_oth = REF_ACTIVE ? los_q[0] : los_q[1];
    wire prim_back = sel_q ? reval_done_q[1] : reval_done_q[0];
    reg los_act_d1_q;
    reg failed_q;
    wire hold_exp = hold_run_q && tick && (hold_cnt_q <= 8'h01);
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            los_act_d1_q <= 1'b0;
            hold_run_q <= 1'b0;
            hold_cnt_q <= `RHR_RST_PERIOD;
            failed_q <= 1'b0;
            REF_ACTIVE <= 1'b0;
            LOS_A <= 1'b0;
            LOS_B <= 1'b0;
        end else begin
            LOS_A <= los_q[0];
            LOS_B <= los_q[1];
            los_act_d1_q <= los_act;
            if (!hold_run_q) begin
                hold_cnt_q <= period_q;
            end
            if (!internal) begin
                // external select; select bit and modes ignored
                REF_ACTIVE <= sync_x_q[1];
                hold_run_q <= 1'b0;
                failed_q <= 1'b0;
            end else if (hold_exp) begin
                REF_ACTIVE <= !REF_ACTIVE;
                hold_cnt_q <= period_q;
                hold_run_q <= 1'b0;
                failed_q <= 1'b1;
            end else if (hold_run_q) begin
                if (tick) begin
                    hold_cnt_q <= hold_cnt_q - 8'h01;
                end
                if (!los_act) begin
                    hold_run_q <= 1'b0;
                end
            end else if (uses_hold && los_act && !los_act_d1_q) begin
                hold_run_q <= 1'b1;
                hold_cnt_q <= period_q;
            end else if (manual && !failed_q) begin
                REF_ACTIVE <= sel_q;
            end else if (!manual) begin
                if (mode_q == `RHR_MODE_AUTO && los_act && !los_oth) begin
                    REF_ACTIVE <= !REF_ACTIVE;
                end else if (rev_en_q && prim_back) begin
                    REF_ACTIVE <= sel_q;
                end
            end
            // a fresh write of the select bit in manual mode re-arms it
            // a fail-over in the same cycle wins over the re-arm
            if (do_write && aw_addr_q == `RHR_ADDR_CTRL && manual &&
                !hold_exp) begin
                failed_q <= 1'b0;
            end
        end
    end
endmodule
